// [dv/asr_host_model.sv]
// Host model that drives the three-wire serial port of the converter.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Serial host
// ----------------------------------------------------------------
module asr_host_model (
  output logic      sclk_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  // The serial clock stands low between frames.
  initial begin
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end

  // One frame: a leading byte, then nbits of readout.
  // Readout bits are sampled on the falling edge, after the
  // device has moved its output on the rising edge.
  task automatic xfer(input logic [7:0] lead, input int nbits,
                      output logic [383:0] got);
    got = '0;
    for (int k = 0; k < 8 + nbits; k++) begin
      sdi_o = (k < 8) ? lead[7 - k] : 1'b0;
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
      if (k >= 7 && k < 7 + nbits) begin
        got = {got[382:0], sdo_i};
      end
    end
    // A released line must not keep showing its last level.
    sdi_o = ~sdi_o;
    // Gap between bytes, so the system side sees each one.
    #600;
  endtask

  // Bare clocks with the data line low. Once reset is released the link
  // spends exactly two edges leaving reset, so those edges carry no bits.
  task automatic clocks(input int n);
    sdi_o = 1'b0;
    repeat (n) begin
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [dv/asr_top_bench.sv]
// Self-checking bench of the setup sequencer and readout block.
`timescale 1ns/1ps
`default_nettype none

module asr_top_bench;
  import asr_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic               sys_clk, rst_b, sclk, serial_in_line, serial_out_line;
  logic               mc, lp, rc, conv_done, mod_osc, cal_done;
  logic               conv_start, conv_bip, cal_start, busy;
  logic [1:0]         conv_chan;
  logic [2:0]         cal_type, exp_cal;
  logic [3:0]         depth;
  logic [31:0]        chans, rnd;
  logic [15:0]        bips;
  logic signed [25:0] raw;
  logic [23:0]        cal_val, offs, gain, v_off, v_gain;
  logic [23:0]        q[$];       // Expected result words in order.
  logic [383:0]       got;
  int                 idx, depth_m, nstart, err_total, checks;
  bit                 multi;

  asr_top i_asr_top (
    .SYS_CLK_I              (sys_clk),
    .RST_B_I                (rst_b),
    .SCLK_I                 (sclk),
    .SERIAL_IN_LINE_I       (serial_in_line),
    .SERIAL_OUT_LINE_O      (serial_out_line),
    .MULTI_SETUP_SELECT_I   (mc),
    .LOOP_SELECT_I          (lp),
    .WAIT_FOR_READ_SELECT_I (rc),
    .SETUP_DEPTH_FIELD_I    (depth),
    .SETUP_CHAN_I           (chans),
    .SETUP_BIPOLAR_I        (bips),
    .CONV_START_O           (conv_start),
    .CONV_CHAN_O            (conv_chan),
    .CONV_BIPOLAR_O         (conv_bip),
    .CONV_DONE_I            (conv_done),
    .CONV_RAW_I             (raw),
    .MOD_OSC_I              (mod_osc),
    .CAL_START_O            (cal_start),
    .CAL_TYPE_O             (cal_type),
    .CAL_DONE_I             (cal_done),
    .CAL_VALUE_I            (cal_val),
    .CHAN_OFFSET_O          (offs),
    .CHAN_GAIN_O            (gain),
    .BUSY_O                 (busy)
  );

  asr_host_model i_asr_host_model (
    .sclk_o (sclk),
    .sdi_o  (serial_in_line),
    .sdo_i  (serial_out_line)
  );

  // The system clock toggles every half period of 25 ns.
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Inputs change a fixed 1 ns after the rising edge.
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  // Pseudo-random source; several shifts per draw decorrelate it.
  task automatic roll();
    repeat (7) rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
  endtask

  // Compare one value and count it.
  task automatic check(input logic [23:0] g, e, input string what);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, g, e);
    end
  endtask

  // Reference slot word: clamp, code, then the monitor byte.
  function automatic logic [23:0] fmt(int r, bit bp, bit o,
                                      logic [1:0] ch);
    int lo;
    int hi;
    int v;
    bit ov;
    lo = bp ? -32768 : 0;
    hi = bp ? 32767 : 65535;
    ov = (r > hi) || (r < lo);
    v  = (r > hi) ? hi : ((r < lo) ? lo : r);
    return {v[15:0], 4'h0, o, ov, ch};
  endfunction

  // Bounded wait for the ready level on the serial output.
  task automatic wait_rdy();
    int n;
    n = 0;
    while (serial_out_line !== 1'b0 && n < 20000) begin
      tick();
      n++;
    end
    check({23'h0, serial_out_line}, 24'h0, "ready low");
  endtask

  // Bounded wait until the sequencer has gone idle.
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      tick();
      n++;
    end
    check({23'h0, busy}, 24'h0, "idle");
  endtask

  // Clock out a set behind a flag byte and compare each word.
  task automatic read_set(input logic [7:0] lead, input int n);
    i_asr_host_model.xfer(lead, 24 * n, got);
    for (int k = 0; k < n; k++) begin
      check(got[24*(n-k)-1 -: 24], q.pop_front(), "word");
    end
  endtask

  // ----------------------------------------------------------------
  // Front end model: answers conversion and calibration starts
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] ch;
    int         r;
    bit         bp;
    bit         o;
    forever begin
      tick();
      if (conv_start === 1'b1) begin
        nstart++;
        ch = chans[2*idx +: 2];
        bp = bips[idx];
        check({21'h0, conv_bip, conv_chan}, {21'h0, bp, ch}, "setup");
        idx = (multi && idx < depth_m) ? idx + 1 : 0;
        roll();
        r = int'(rnd % 32'd140001) - 70000;
        o = rnd[20];
        q.push_back(fmt(r, bp, o, ch));
        repeat (20 + rnd[4:0]) @(posedge sys_clk);
        #1;
        raw       = 26'(r);
        mod_osc   = o;
        conv_done = 1'b1;
        tick();
        conv_done = 1'b0;
      end else if (cal_start === 1'b1) begin
        check({21'h0, cal_type}, {21'h0, exp_cal}, "cal type");
        roll();
        repeat (30) @(posedge sys_clk);
        #1;
        cal_val  = rnd[23:0];
        cal_done = 1'b1;
        if (exp_cal[1]) v_gain = rnd[23:0];
        else v_off = rnd[23:0];
        tick();
        cal_done = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Verdict and watchdog
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rnd = 32'h000169C5;
    {rst_b, mc, lp, rc, conv_done, mod_osc, cal_done} = '0;
    {depth, raw, cal_val, exp_cal, v_off, v_gain} = '0;
    {idx, depth_m, nstart, err_total, checks, multi} = '0;
    roll();
    chans = rnd;
    roll();
    bips = rnd[15:0];
    // Link flops need serial edges while reset is held, then exactly two
    // more to leave reset; a third would be taken as a command bit.
    fork
      begin
        repeat (10) tick();
        rst_b = 1'b1;
      end
      i_asr_host_model.clocks(8);
    join
    i_asr_host_model.clocks(2);
    // A null byte in command mode starts nothing.
    i_asr_host_model.xfer(8'h00, 0, got);
    repeat (40) tick();
    check({23'h0, busy}, 24'h0, "null busy");
    check(24'(nstart), 24'h0, "null start");
    check({23'h0, serial_out_line}, 24'h1, "null sdo");
    // Single conversion on setup 5, address from the command.
    idx = 5;
    i_asr_host_model.xfer(8'hA8, 0, got);
    wait_rdy();
    read_set(8'h00, 1);
    wait_idle();
    // Looped sets without and with wait, depth 9 then 15.
    for (int m = 0; m < 2; m++) begin
      tick();
      mc      = 1'b1;
      lp      = 1'b1;
      rc      = m[0];
      depth   = m ? 4'hF : 4'h9;
      depth_m = int'(depth);
      multi   = 1'b1;
      idx     = 0;
      i_asr_host_model.xfer(8'hC8, 0, got);
      wait_rdy();
      read_set(8'h00, depth_m + 1);
      wait_rdy();
      read_set(8'hFF, depth_m + 1);
      wait_idle();
      repeat (80) tick();
      q.delete();
      check({23'h0, serial_out_line}, 24'h1, "command mode");
    end
    // Setups 5 and 7 share one physical channel.
    chans[15:14] = chans[11:10];
    multi   = 1'b0;
    exp_cal = 3'b101;
    i_asr_host_model.xfer(8'hAD, 0, got);
    wait_rdy();
    repeat (3) tick();
    check(offs, v_off, "offset stored");
    exp_cal = 3'b010;
    i_asr_host_model.xfer(8'hBA, 0, got);
    wait_rdy();
    repeat (3) tick();
    check(gain, v_gain, "gain stored");
    check(offs, v_off, "offset shared");
    give_verdict();
  end
endmodule
`default_nettype wire

// [verilog/asr_defines.svh]
// Constants of the setup sequencer and readout block.
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH
`define ASR_CMD_BIT     7
`define ASR_PTR_HI      6
`define ASR_PTR_LO      3
`define ASR_CC_HI       2
`define ASR_CC_LO       0
`define ASR_CC_CONVERT  3'h0
`define ASR_CC_GAIN_BIT 1
`define ASR_NULL_BYTE   8'h00
`define ASR_EXIT_BYTE   8'hFF
`define ASR_BYTE_LAST   5'h07
`define ASR_WORD_LAST   5'h17
`define ASR_SLOT_OF     2
`define ASR_SLOT_OD     3
`define ASR_ZERO26      26'sh0000000
`define ASR_U16_MAX     26'sh000FFFF
`define ASR_S16_MAX     26'sh0007FFF
`define ASR_S16_MIN     26'sh3FF8000
`define ASR_U24_MAX     26'sh0FFFFFF
`define ASR_S24_MAX     26'sh07FFFFF
`define ASR_S24_MIN     26'sh3800000
`define ASR_ONES24      24'hFFFFFF
`endif

// [verilog/asr_pkg.sv]
// Types of the setup sequencer and readout block.
`default_nettype none
package asr_pkg;
  typedef enum logic [2:0] {
    SQ_IDLE  = 3'h0,
    SQ_START = 3'h1,
    SQ_WAIT  = 3'h2,
    SQ_CAL   = 3'h3,
    SQ_HOLD  = 3'h4
  } asr_seq_type;
  typedef enum logic [1:0] {
    LK_CMD  = 2'h0,
    LK_DATA = 2'h1
  } asr_link_type;
endpackage
`default_nettype wire

// [verilog/asr_top.sv]
// Setup sequencer, result formatter and serial readout of the converter.
`timescale 1ns/1ps
`default_nettype none
`include "asr_defines.svh"

// Two-stage synchroniser; stage one is read only by stage two.
module asr_sync #(parameter int W = 1) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_ff <= '0;
      q_o   <= '0;
    end else begin
      s1_ff <= d_i;
      q_o   <= s1_ff;
    end
  end
endmodule

// Operation
// - Looped multi mode converts depth plus one setups.
// - Results leave in conversion order.
// - Three bytes per setup, first setup first.
// - All-ones byte exits after FIFO drains; without wait the loop ends at the flag byte.
// - One offset and gain per channel.
// - Calibrate addressed setup, signal done low.
// - Select bit picks command or sequenced setups.
// - One command starts up to sixteen setups.
// - Null command keeps command mode.
// - 384-bit FIFO, words leave MSB first.
// - Unipolar straight binary, bipolar two's complement.
// - Sixteen-bit results clamp to their limits.
// - Twenty-four-bit results clamp to their limits.
// - Results sit in a 24-bit slot.
// - Sixteen-bit low byte carries monitor flags.
// - Oscillation flag follows modulator stability.
// - Overrange flag marks out-of-span input.
// - Channel tag codes channels one to four.
module asr_top
  import asr_pkg::*;
#(
  parameter bit WIDE24 = 1'b0,  // 1 selects the 24-bit variant.
  parameter int SLOTS  = 16,    // Result slots, one per setup.
  parameter int CHANS  = 4      // Physical input channels.
) (
  input  wire logic               SYS_CLK_I,
  input  wire logic               RST_B_I,
  input  wire logic               SCLK_I,
  input  wire logic               SERIAL_IN_LINE_I,
  output logic                    SERIAL_OUT_LINE_O,
  input  wire logic               MULTI_SETUP_SELECT_I,
  input  wire logic               LOOP_SELECT_I,
  input  wire logic               WAIT_FOR_READ_SELECT_I,
  input  wire logic [3:0]         SETUP_DEPTH_FIELD_I,
  input  wire logic [2*SLOTS-1:0] SETUP_CHAN_I,
  input  wire logic [SLOTS-1:0]   SETUP_BIPOLAR_I,
  output logic                    CONV_START_O,
  output logic [1:0]              CONV_CHAN_O,
  output logic                    CONV_BIPOLAR_O,
  input  wire logic               CONV_DONE_I,
  input  wire logic signed [25:0] CONV_RAW_I,
  input  wire logic               MOD_OSC_I,
  output logic                    CAL_START_O,
  output logic [2:0]              CAL_TYPE_O,
  input  wire logic               CAL_DONE_I,
  input  wire logic [23:0]        CAL_VALUE_I,
  output logic [23:0]             CHAN_OFFSET_O,
  output logic [23:0]             CHAN_GAIN_O,
  output logic                    BUSY_O
);
  // ---------------------------------------------------------------
  // Shared state
  // ---------------------------------------------------------------
  asr_seq_type  seq_ff;           // Sequencer state.
  asr_link_type lk_ff;            // Link state.
  logic [23:0] slot_ff [SLOTS];   // Result storage, sys domain.
  logic [23:0] offs_ff [CHANS];   // Offset per physical channel.
  logic [23:0] gain_ff [CHANS];   // Gain per physical channel.
  logic [3:0]  idx_ff;            // Setup being converted.
  logic [3:0]  last_ff;           // Final setup of the set.
  logic [3:0]  wr_ff;             // Slot being written.
  logic [4:0]  count_ff;          // Results in the ready set.
  logic        multi_ff;          // Latched sequencing mode.
  logic        loop_ff;           // Latched loop mode.
  logic        wait_ff;           // Latched wait-for-read mode.
  logic        rdy_ff;            // Ready flag, drives line low.
  logic        is_cal_ff;         // Ready flag came from calibration.
  logic [7:0]  cmd_ff;            // Last command byte, link domain.
  logic        exit_ff;           // Flag byte was all ones.
  logic [2:0]  tgl_ff;            // Command, clear, read-done toggles.
  logic [2:0]  tgl_s;             // Toggles seen in sys domain.
  logic [2:0]  tgl_d_ff;          // Previous synchronised toggles.
  logic [2:0]  ev;                // One-cycle link events.
  logic        lk_rst_b;          // Reset in link domain.
  logic        rdy_s;             // Ready flag in link domain.
  logic [7:0]  rx_ff;             // Incoming bits.
  logic [4:0]  bit_ff;            // Bit counter in byte or word.
  logic [3:0]  word_ff;           // Word being shifted out.
  logic [23:0] tx_ff;             // Outgoing word, MSB at top.
  logic [7:0]  byte_in;           // Byte completing now.
  logic [23:0] fmt;               // Formatted result.
  logic [3:0]  first;             // First setup of a set.
  logic [3:0]  ptr;               // Setup addressed by command.
  logic [1:0]  cur_ch;            // Channel of current setup.
  logic        wr_now;            // Result written this cycle.

  assign ev      = tgl_s ^ tgl_d_ff;
  assign ptr     = cmd_ff[`ASR_PTR_HI:`ASR_PTR_LO];
  assign first   = MULTI_SETUP_SELECT_I ? 4'h0 : ptr;
  assign cur_ch  = SETUP_CHAN_I[2*idx_ff +: 2];
  assign wr_now  = (seq_ff == SQ_WAIT) && CONV_DONE_I;
  assign byte_in = {rx_ff[6:0], SERIAL_IN_LINE_I};

  // Line is low while a result or calibration waits; during readout the
  // link word drives it. Gating keeps the flag off the first data bits.
  assign SERIAL_OUT_LINE_O = tx_ff[23] & (~rdy_ff | (lk_ff == LK_DATA));

  asr_sync #(.W(3)) u_sync_sys (
    .clk_i   (SYS_CLK_I),
    .rst_b_i (RST_B_I),
    .d_i     (tgl_ff),
    .q_o     (tgl_s)
  );
  asr_sync #(.W(2)) u_sync_lk (
    .clk_i   (SCLK_I),
    .rst_b_i (1'b1),
    .d_i     ({RST_B_I, rdy_ff}),
    .q_o     ({lk_rst_b, rdy_s})
  );

  // ---------------------------------------------------------------
  // Result formatting
  // ---------------------------------------------------------------
  // Clamps to the span of the coding in use; the 16-bit slot also flags overrange.
  function automatic logic [23:0] fmt_slot(
    input logic signed [25:0] raw, input logic bip,
    input logic osc, input logic [1:0] ch);
    logic signed [25:0] lo;
    logic signed [25:0] hi;
    logic signed [25:0] c;
    logic [23:0]        f;
    lo = bip ? (WIDE24 ? `ASR_S24_MIN : `ASR_S16_MIN) : `ASR_ZERO26;
    hi = bip ? (WIDE24 ? `ASR_S24_MAX : `ASR_S16_MAX)
             : (WIDE24 ? `ASR_U24_MAX : `ASR_U16_MAX);
    c = (raw > hi) ? hi : ((raw < lo) ? lo : raw);
    if (WIDE24) begin
      f = c[23:0];
    end else begin
      f = {c[15:0], 8'h00};
      f[`ASR_SLOT_OD] = osc;
      f[`ASR_SLOT_OF] = (raw > hi) || (raw < lo);
      f[1:0] = ch;
    end
    return f;
  endfunction

  assign fmt = fmt_slot(CONV_RAW_I, SETUP_BIPOLAR_I[idx_ff], MOD_OSC_I,
                        cur_ch);

  // ---------------------------------------------------------------
  // Sequencer, system domain
  // ---------------------------------------------------------------
  // Commands arrive as a toggle; the byte is held still by the link.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      seq_ff <= SQ_IDLE;
      idx_ff <= 4'h0;
      last_ff <= 4'h0;
      wr_ff <= 4'h0;
      multi_ff <= 1'b0;
      loop_ff <= 1'b0;
      wait_ff <= 1'b0;
    end else begin
      case (seq_ff)
        SQ_IDLE: begin
          // Null and non-command bytes leave the port idle.
          if (ev[0] && cmd_ff[`ASR_CMD_BIT]) begin
            idx_ff <= first;
            last_ff <= MULTI_SETUP_SELECT_I ? SETUP_DEPTH_FIELD_I : ptr;
            wr_ff <= 4'h0;
            multi_ff <= MULTI_SETUP_SELECT_I;
            loop_ff <= LOOP_SELECT_I;
            wait_ff <= WAIT_FOR_READ_SELECT_I;
            if (cmd_ff[`ASR_CC_HI:`ASR_CC_LO] == `ASR_CC_CONVERT) begin
              seq_ff <= SQ_START;
            end else begin
              idx_ff <= ptr;
              seq_ff <= SQ_CAL;
            end
          end
        end
        SQ_START: begin
          seq_ff <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (CONV_DONE_I) begin
            if (idx_ff == last_ff) begin
              seq_ff <= SQ_HOLD;
            end else begin
              idx_ff <= idx_ff + 4'h1;
              wr_ff <= wr_ff + 4'h1;
              seq_ff <= SQ_START;
            end
          end
        end
        SQ_CAL: begin
          if (CAL_DONE_I) begin
            seq_ff <= SQ_IDLE;
          end
        end
        SQ_HOLD: begin
          // Without wait the next set starts once the flag is cleared;
          // with wait it starts once the whole set has been read.
          if (!loop_ff) begin
            seq_ff <= SQ_IDLE;
          end else if ((!wait_ff && ev[1]) || (wait_ff && ev[2])) begin
            if (exit_ff) begin
              seq_ff <= SQ_IDLE;
            end else begin
              idx_ff <= multi_ff ? 4'h0 : idx_ff;
              wr_ff <= 4'h0;
              seq_ff <= SQ_START;
            end
          end
        end
        default: begin
          seq_ff <= SQ_IDLE;
        end
      endcase
    end
  end

  // Result slots take the formatted word in conversion order.
  always_ff @(posedge SYS_CLK_I) begin
    if (wr_now) begin
      slot_ff[wr_ff] <= fmt;
    end
  end

  // Ready flag: a new set or calibration wins over a clear.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      rdy_ff <= 1'b0;
      is_cal_ff <= 1'b0;
      count_ff <= 5'h00;
      tgl_d_ff <= 3'h0;
    end else begin
      tgl_d_ff <= tgl_s;
      if (wr_now && (idx_ff == last_ff)) begin
        rdy_ff <= 1'b1;
        is_cal_ff <= 1'b0;
        count_ff <= {1'b0, wr_ff} + 5'h01;
      end else if ((seq_ff == SQ_CAL) && CAL_DONE_I) begin
        rdy_ff <= 1'b1;
        is_cal_ff <= 1'b1;
      end else if (ev[1]) begin
        rdy_ff <= 1'b0;
      end
    end
  end

  // Calibration results land in the store of the physical channel,
  // so every setup naming that channel shares them.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < CHANS; i++) begin
        offs_ff[i] <= 24'h000000;
        gain_ff[i] <= 24'h000000;
      end
    end else if ((seq_ff == SQ_CAL) && CAL_DONE_I) begin
      if (CAL_TYPE_O[`ASR_CC_GAIN_BIT]) begin
        gain_ff[cur_ch] <= CAL_VALUE_I;
      end else begin
        offs_ff[cur_ch] <= CAL_VALUE_I;
      end
    end
  end

  // Front-end controls, all registered.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      CONV_START_O <= 1'b0;
      CONV_CHAN_O <= 2'h0;
      CONV_BIPOLAR_O <= 1'b0;
      CAL_START_O <= 1'b0;
      CAL_TYPE_O <= 3'h0;
      CHAN_OFFSET_O <= 24'h000000;
      CHAN_GAIN_O <= 24'h000000;
      BUSY_O <= 1'b0;
    end else begin
      CONV_START_O <= (seq_ff == SQ_START);
      CAL_START_O <= (seq_ff == SQ_IDLE) && ev[0] &&
                     cmd_ff[`ASR_CMD_BIT] &&
                     (cmd_ff[`ASR_CC_HI:`ASR_CC_LO] != `ASR_CC_CONVERT);
      if (seq_ff == SQ_IDLE) begin
        CAL_TYPE_O <= cmd_ff[`ASR_CC_HI:`ASR_CC_LO];
      end
      CONV_CHAN_O <= cur_ch;
      CONV_BIPOLAR_O <= SETUP_BIPOLAR_I[idx_ff];
      CHAN_OFFSET_O <= offs_ff[cur_ch];
      CHAN_GAIN_O <= gain_ff[cur_ch];
      BUSY_O <= (seq_ff != SQ_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Serial link, link clock domain
  // ---------------------------------------------------------------
  // Bits are taken and launched on the rising edge. A byte ending while
  // a result set waits is the flag byte; otherwise it is a command.
  always_ff @(posedge SCLK_I) begin
    if (!lk_rst_b) begin
      lk_ff <= LK_CMD;
      rx_ff <= 8'h00;
      bit_ff <= 5'h00;
      word_ff <= 4'h0;
      tx_ff <= `ASR_ONES24;
      cmd_ff <= `ASR_NULL_BYTE;
      exit_ff <= 1'b0;
      tgl_ff <= 3'h0;
    end else begin
      rx_ff <= byte_in;
      case (lk_ff)
        LK_CMD: begin
          bit_ff <= (bit_ff == `ASR_BYTE_LAST) ? 5'h00 : bit_ff + 5'h01;
          if (bit_ff == `ASR_BYTE_LAST) begin
            if (rdy_s && !is_cal_ff) begin
              exit_ff <= (byte_in == `ASR_EXIT_BYTE);
              tgl_ff[1] <= ~tgl_ff[1];
              word_ff <= 4'h0;
              tx_ff <= slot_ff[0];
              lk_ff <= LK_DATA;
            end else begin
              cmd_ff <= byte_in;
              tgl_ff[0] <= ~tgl_ff[0];
              if (rdy_s) begin
                tgl_ff[1] <= ~tgl_ff[1];
              end
            end
          end
        end
        LK_DATA: begin
          if (bit_ff == `ASR_WORD_LAST) begin
            bit_ff <= 5'h00;
            word_ff <= word_ff + 4'h1;
            if (({1'b0, word_ff} + 5'h01) == count_ff) begin
              tx_ff <= `ASR_ONES24;
              tgl_ff[2] <= ~tgl_ff[2];
              lk_ff <= LK_CMD;
            end else begin
              tx_ff <= slot_ff[word_ff + 4'h1];
            end
          end else begin
            bit_ff <= bit_ff + 5'h01;
            tx_ff <= {tx_ff[22:0], 1'b1};
          end
        end
        default: begin
          lk_ff <= LK_CMD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_set_depth: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    $rose(rdy_ff) && !is_cal_ff && multi_ff
    |-> count_ff == {1'b0, SETUP_DEPTH_FIELD_I} + 5'h01)
    else $error("set size differs from depth plus one");
  chk_multi_first: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    seq_ff == SQ_IDLE && ev[0] && cmd_ff[`ASR_CMD_BIT]
    |=> idx_ff == ((multi_ff && ($past(cmd_ff[`ASR_CC_HI:`ASR_CC_LO]) ==
                    `ASR_CC_CONVERT)) ? 4'h0 : $past(ptr)))
    else $error("wrong first setup");
  chk_null_idle: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    seq_ff == SQ_IDLE && ev[0] && cmd_ff == `ASR_NULL_BYTE
    |=> seq_ff == SQ_IDLE ##1 !CONV_START_O && !CAL_START_O)
    else $error("null command left command mode");
  chk_uni_floor: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    wr_now && !SETUP_BIPOLAR_I[idx_ff] && CONV_RAW_I < 0
    |=> slot_ff[$past(wr_ff)][23:8] == 16'h0000)
    else $error("unipolar result not clamped at zero");
  chk_flag_byte: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    wr_now && !WIDE24 |=> slot_ff[$past(wr_ff)][7:4] == 4'h0 &&
    slot_ff[$past(wr_ff)][1:0] == $past(cur_ch) &&
    slot_ff[$past(wr_ff)][`ASR_SLOT_OD] == $past(MOD_OSC_I))
    else $error("monitor byte malformed");
  chk_cal_done: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    seq_ff == SQ_CAL && CAL_DONE_I |=> rdy_ff && is_cal_ff && !SERIAL_OUT_LINE_O)
    else $error("calibration end not flagged");
  chk_cal_store: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
    seq_ff == SQ_CAL && CAL_DONE_I && CAL_TYPE_O[`ASR_CC_GAIN_BIT]
    |=> gain_ff[$past(cur_ch)] == $past(CAL_VALUE_I))
    else $error("gain not stored per channel");
  chk_msb_first: assert property (@(posedge SCLK_I) disable iff (!lk_rst_b)
    lk_ff == LK_DATA && bit_ff != `ASR_WORD_LAST |=> tx_ff[23] == $past(tx_ff[22]))
    else $error("word not shifted MSB first");
  chk_drain_cmd: assert property (@(posedge SCLK_I) disable iff (!lk_rst_b)
    lk_ff == LK_DATA && bit_ff == `ASR_WORD_LAST &&
    ({1'b0, word_ff} + 5'h01) == count_ff |=> lk_ff == LK_CMD)
    else $error("port not back in command mode after drain");
  cov_set_ready: cover property (@(posedge SYS_CLK_I) $rose(rdy_ff) && !is_cal_ff);
  cov_cal_ready: cover property (@(posedge SYS_CLK_I) $rose(rdy_ff) && is_cal_ff);
  cov_loop_exit: cover property (@(posedge SYS_CLK_I)
    seq_ff == SQ_HOLD && loop_ff && exit_ff ##1 seq_ff == SQ_IDLE);
endmodule
`default_nettype wire
